// ### tms_pkg.sv
// Constants shared by the T1 multiframe synchronizer files
package tms_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_ISTA = 8'h08;
  localparam logic [7:0] OFF_IMSK = 8'h0C;
  // Control field positions and reset value
  localparam int CTL_FMT_LSB  = 0;
  localparam int CTL_RAS      = 2;
  localparam int CTL_SEP      = 3;
  localparam int CTL_CRIT_LSB = 4;
  localparam int CTL_FORCE    = 6;
  localparam logic [5:0] CTRL_RST = 6'h00;
  // Status field positions
  localparam int STA_LFA      = 0;
  localparam int STA_LMFA     = 1;
  localparam int STA_RA       = 2;
  localparam int STA_FRM_LSB  = 8;
  // Interrupt bits
  localparam int IRQ_LFA      = 0;
  localparam int IRQ_LMFA     = 1;
  localparam int IRQ_RA       = 2;
  localparam int IRQ_W        = 3;
  // Format codes
  localparam logic [1:0] FMT_F4  = 2'h0;
  localparam logic [1:0] FMT_F12 = 2'h1;
  localparam logic [1:0] FMT_ESF = 2'h2;
  localparam logic [1:0] FMT_F72 = 2'h3;
  localparam logic [6:0] LEN_F4  = 7'h04;
  localparam logic [6:0] LEN_F12 = 7'h0C;
  localparam logic [6:0] LEN_ESF = 7'h18;
  localparam logic [6:0] LEN_F72 = 7'h48;
  // Loss criteria code for the ESF consecutive-pattern test
  localparam logic [1:0] CRIT_ESF4 = 2'h3;
  // Frame geometry
  localparam logic [7:0] BIT_LAST  = 8'hC0;
  localparam logic [6:0] SF_LAST   = 7'h0B;
  localparam logic [6:0] ESF_LAST  = 7'h17;
  // Expected patterns, bit k = k-th pattern position
  localparam logic [5:0] SF_PAT  = 6'h1C;
  localparam logic [5:0] ESF_PAT = 6'h34;
  // Search and loss counts
  localparam logic [3:0] FT_LOCK    = 4'h4;
  localparam logic [3:0] ESF_LOCK   = 4'hC;
  localparam logic [3:0] MF_GOOD    = 4'hC;
  localparam logic [2:0] MF_BAD_MAX = 3'h4;
endpackage

// ### tms_win_if.sv
// Framing error window link between synchronizer and window checker
`timescale 1ns/1ps
`default_nettype none
interface tms_win_if;
  logic       ev;
  logic       err;
  logic       clr;
  logic [1:0] sel;
  logic       loss;
  modport mon (input ev, err, clr, sel, output loss);
  modport src (output ev, err, clr, sel, input loss);
endinterface
`default_nettype wire

// ### tms_err_win.sv
// Two-errors-in-window checker over framing bit results
`timescale 1ns/1ps
`default_nettype none
module tms_err_win #(
  parameter int DEPTH = 6
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Window link
  tms_win_if.mon    w
);
  logic [DEPTH-1:0] hist_reg;
  logic [DEPTH-1:0] span;

  // Older results inside the selected window of 4 + sel bits
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_span
      assign span[i] = hist_reg[i] & (3'(i) < ({1'b0, w.sel} + 3'h3));
    end
  endgenerate

  assign w.loss = w.ev & w.err & (|span);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_reg <= '0;
    end else if (w.clr) begin
      hist_reg <= '0;
    end else if (w.ev) begin
      hist_reg <= {hist_reg[DEPTH-2:0], w.err};
    end
  end

  property p_single_err;
    @(posedge pclk) disable iff (!presetn)
      (w.ev && w.err && hist_reg == '0) |-> !w.loss;
  endproperty
  a_single_err: assert property (p_single_err) else $error("Loss on a single error");

  property p_double_err;
    @(posedge pclk) disable iff (!presetn)
      (w.ev && w.err && hist_reg[0]) |-> w.loss;
  endproperty
  a_double_err: assert property (p_double_err) else $error("Two errors in a row missed");
endmodule
`default_nettype wire

// ### tms_pos_cnt.sv
// Bit and frame position counter with slip and frame jump
`timescale 1ns/1ps
`default_nettype none
module tms_pos_cnt (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       bit_stb,
  input  wire logic       slip,
  input  wire logic       jump,
  input  wire logic [6:0] len,
  // Position
  output logic      [7:0] bit_idx,
  output logic      [6:0] frame_idx
);
  logic [7:0] bit_idx_reg;
  logic [6:0] frame_idx_reg;

  wire       bit_wrap  = bit_idx_reg == tms_pkg::BIT_LAST;
  wire [6:0] f_inc     = frame_idx_reg + (jump ? 7'h04 : 7'h01);
  wire [6:0] f_next    = (f_inc >= len) ? f_inc - len : f_inc;
  wire       f_bad     = frame_idx_reg >= len;

  // Frame count modulo multiframe length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_idx_reg   <= '0;
      frame_idx_reg <= '0;
    end else if (f_bad) begin
      frame_idx_reg <= '0;
    end else if (bit_stb && !slip) begin
      bit_idx_reg <= bit_wrap ? 8'h00 : bit_idx_reg + 8'h01;
      if (bit_wrap || jump) begin
        frame_idx_reg <= f_next;
      end
    end
  end

  assign bit_idx   = bit_idx_reg;
  assign frame_idx = frame_idx_reg;

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      (bit_stb && !slip && bit_wrap && !f_bad) |=> bit_idx_reg == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("Bit counter did not wrap");
endmodule
`default_nettype wire

// ### tms_mf_sync.sv
// T1 receive multiframe synchronizer with APB registers
`timescale 1ns/1ps
`default_nettype none
module tms_mf_sync (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Line pins
  input  wire logic        line_clk,
  input  wire logic        line_data,
  // Alignment status
  output logic             frame_align_lost_flag,
  output logic             multiframe_align_lost_flag,
  output logic             remote_alarm,
  output logic      [6:0]  frame_num,
  // Extracted positions
  output logic             link_channel_bit,
  output logic             link_channel_valid,
  output logic             crc_bit,
  output logic             crc_valid,
  output logic             sig_frame,
  output logic      [1:0]  sig_chan,
  // Interrupt
  output logic             irq
);
  localparam int IRQ_W_C = tms_pkg::IRQ_W - 1;
  logic [2:0]        lclk_sync_reg;
  logic [1:0]        ldat_sync_reg;
  logic [5:0]        ctrl_reg;
  logic [IRQ_W_C:0]  ista_reg;
  logic [IRQ_W_C:0]  imsk_reg;
  logic              lfa_reg, lfa_next;
  logic              lmfa_reg, lmfa_next;
  logic              force_pend_reg;
  logic [3:0]        tgood_reg, mgood_reg;
  logic [2:0]        mbad_reg;
  logic              mf_err_reg;
  logic              ts_one_reg;
  logic              ra_reg, ra_next;
  logic [31:0]       prdata_reg;
  logic              pready_reg, pslverr_reg, irq_reg;
  logic [6:0]        frame_num_reg;
  logic              dl_bit_reg, dl_valid_reg, crc_bit_reg, crc_valid_reg;
  logic              sig_frame_reg;
  logic [1:0]        sig_chan_reg;
  logic [7:0]        bit_idx;
  logic [6:0]        frame_idx;
  logic [1:0]        sig_chan_dec;
  logic              sig_dec;

  // Line clock and data pass two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lclk_sync_reg <= '0;
      ldat_sync_reg <= '0;
    end else begin
      lclk_sync_reg <= {lclk_sync_reg[1:0], line_clk};
      ldat_sync_reg <= {ldat_sync_reg[0], line_data};
    end
  end
  wire bit_stb = lclk_sync_reg[1] & ~lclk_sync_reg[2];
  wire bit_val = ldat_sync_reg[1];

  // Control fields
  wire [1:0] fmt  = ctrl_reg[tms_pkg::CTL_FMT_LSB +: 2];
  wire       ras  = ctrl_reg[tms_pkg::CTL_RAS];
  wire       sep  = ctrl_reg[tms_pkg::CTL_SEP];
  wire [1:0] crit = ctrl_reg[tms_pkg::CTL_CRIT_LSB +: 2];
  wire       esf  = fmt == tms_pkg::FMT_ESF;
  wire       f4   = fmt == tms_pkg::FMT_F4;
  wire       f12  = fmt == tms_pkg::FMT_F12;
  wire [6:0] len  = f4  ? tms_pkg::LEN_F4  : f12 ? tms_pkg::LEN_F12 :
                    esf ? tms_pkg::LEN_ESF : tms_pkg::LEN_F72;

  // Framing bit positions and expected values
  wire is_f     = bit_stb & (bit_idx == 8'h00);
  wire ft_pos   = !esf & !frame_idx[0];
  wire ft_exp   = ~frame_idx[1];
  wire fs_pos   = !esf & !f4 & frame_idx[0] & (frame_idx <= tms_pkg::SF_LAST);
  wire fs_exp   = tms_pkg::SF_PAT[frame_idx[3:1]];
  wire fas_pos  = esf & (frame_idx[1:0] == 2'h3);
  wire fas_exp  = tms_pkg::ESF_PAT[frame_idx[4:2]];
  wire ra_fs    = ras & f12 & (frame_idx == tms_pkg::SF_LAST) & bit_val;
  wire fs_ok    = (bit_val == fs_exp) | ra_fs;
  wire term_pos = ft_pos | fas_pos;
  wire term_ok  = ft_pos ? (bit_val == ft_exp) : (bit_val == fas_exp);
  wire term_ev  = is_f & term_pos;
  wire fs_ev    = is_f & fs_pos;
  wire [3:0] lock_cnt = esf ? tms_pkg::ESF_LOCK : tms_pkg::FT_LOCK;

  // APB decode
  wire setup   = psel & !penable;
  wire wr_acc  = psel & penable & pwrite & pready_reg;
  wire hit_ctl = paddr == tms_pkg::OFF_CTRL;
  wire hit_sta = paddr == tms_pkg::OFF_STAT;
  wire hit_ist = paddr == tms_pkg::OFF_ISTA;
  wire hit_imk = paddr == tms_pkg::OFF_IMSK;
  wire mapped  = hit_ctl | hit_sta | hit_ist | hit_imk;
  wire force_p = wr_acc & hit_ctl & pwdata[tms_pkg::CTL_FORCE];
  wire [31:0] stat_word = {17'h00000, frame_num_reg, 5'h00, ra_reg, lmfa_reg, lfa_reg};
  wire [31:0] rd_mux = hit_ctl ? {26'h0000000, ctrl_reg} :
                       hit_sta ? stat_word :
                       hit_ist ? {29'h00000000, ista_reg} :
                       hit_imk ? {29'h00000000, imsk_reg} : 32'h00000000;

  // Error windows
  tms_win_if tw ();
  tms_win_if mw ();
  assign tw.ev  = term_ev & !lfa_reg;
  assign tw.err = !term_ok;
  assign tw.clr = lfa_reg;
  assign tw.sel = (crit == tms_pkg::CRIT_ESF4) ? 2'h2 : crit;
  assign mw.ev  = fs_ev & !lmfa_reg;
  assign mw.err = !fs_ok;
  assign mw.clr = lmfa_reg;
  assign mw.sel = tw.sel;
  tms_err_win #(.DEPTH(6)) u_term_win (.pclk(pclk), .presetn(presetn), .w(tw));
  tms_err_win #(.DEPTH(6)) u_mf_win (.pclk(pclk), .presetn(presetn), .w(mw));

  // Loss decisions
  wire esf4     = esf & (crit == tms_pkg::CRIT_ESF4);
  wire fas_ev_end = term_ev & esf & (frame_idx == tms_pkg::ESF_LAST);
  wire mf_end   = fas_ev_end & !lfa_reg;
  wire mf_bad   = mf_err_reg | (term_ev & !term_ok);
  wire esf_loss = esf4 & mf_end & mf_bad & (mbad_reg == tms_pkg::MF_BAD_MAX - 3'h1);
  wire term_loss = (tw.loss & !esf4) | esf_loss;
  wire full_loss = term_loss | (mw.loss & !sep);
  wire mf_loss  = mw.loss & sep;

  // Search control
  wire t_hunt  = lfa_reg & term_ev;
  wire t_lock  = t_hunt & term_ok & (force_pend_reg | (tgood_reg == lock_cnt - 4'h1));
  wire slip    = t_hunt & !term_ok;
  wire m_hunt  = !lfa_reg & lmfa_reg & fs_ev;
  wire m_lock  = m_hunt & fs_ok & (mgood_reg == tms_pkg::MF_GOOD - 4'h1);
  wire jump    = m_hunt & !fs_ok;

  tms_pos_cnt u_pos (
    .pclk      (pclk),
    .presetn   (presetn),
    .bit_stb   (bit_stb),
    .slip      (slip),
    .jump      (jump),
    .len       (len),
    .bit_idx   (bit_idx),
    .frame_idx (frame_idx)
  );

  // Alignment state next values
  always_comb begin
    lfa_next  = lfa_reg;
    lmfa_next = lmfa_reg;
    if (force_p && !lfa_reg) begin
      lfa_next  = 1'b1;
      lmfa_next = 1'b1;
    end else if (t_lock) begin
      lfa_next = 1'b0;
      if (esf || f4) begin
        lmfa_next = 1'b0;
      end
    end else if (full_loss) begin
      lfa_next  = 1'b1;
      lmfa_next = 1'b1;
    end else if (mf_loss) begin
      lmfa_next = 1'b1;
    end else if (m_lock) begin
      lmfa_next = 1'b0;
    end
  end

  // Remote alarm per frame, or per multiframe from the frame 12 bit in RAS 12-frame mode
  always_comb begin
    ra_next = ra_reg;
    if (lfa_reg || esf) begin
      ra_next = 1'b0;
    end else if (ras && f12) begin
      if (fs_ev && frame_idx == tms_pkg::SF_LAST) begin
        ra_next = bit_val & !lmfa_reg;
      end
    end else if (is_f) begin
      ra_next = !ts_one_reg;
    end
  end

  // Signaling frame decode
  always_comb begin
    sig_dec      = 1'b0;
    sig_chan_dec = 2'h0;
    case (frame_idx)
      7'h05: begin sig_dec = 1'b1; sig_chan_dec = 2'h0; end
      7'h0B: begin sig_dec = 1'b1; sig_chan_dec = 2'h1; end
      7'h11: begin sig_dec = esf; sig_chan_dec = 2'h2; end
      7'h17: begin sig_dec = esf; sig_chan_dec = 2'h3; end
      default: begin sig_dec = 1'b0; sig_chan_dec = 2'h0; end
    endcase
  end

  wire [IRQ_W_C:0] ev_vec = {ra_next & !ra_reg, lmfa_next & !lmfa_reg, lfa_next & !lfa_reg};
  wire [IRQ_W_C:0] w1c    = (wr_acc && hit_ist) ? pwdata[IRQ_W_C:0] : '0;
  wire [IRQ_W_C:0] ista_next = (ista_reg & ~w1c) | ev_vec;

  // Registers and alignment state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= tms_pkg::CTRL_RST;
      imsk_reg <= '0;
      ista_reg <= '0;
      irq_reg  <= 1'b0;
      lfa_reg  <= 1'b1;
      lmfa_reg <= 1'b1;
      ra_reg   <= 1'b0;
    end else begin
      if (wr_acc && hit_ctl) begin
        ctrl_reg <= pwdata[5:0];
      end
      if (wr_acc && hit_imk) begin
        imsk_reg <= pwdata[IRQ_W_C:0];
      end
      ista_reg <= ista_next;
      irq_reg  <= |(ista_next & imsk_reg);
      lfa_reg  <= lfa_next;
      lmfa_reg <= lmfa_next;
      ra_reg   <= ra_next;
    end
  end

  // APB answer, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
      if (setup) begin
        prdata_reg  <= pwrite ? 32'h00000000 : rd_mux;
        pslverr_reg <= !mapped;
      end
    end
  end

  // Search counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_pend_reg <= 1'b0;
      tgood_reg      <= '0;
      mgood_reg      <= '0;
      mbad_reg       <= '0;
      mf_err_reg     <= 1'b0;
      ts_one_reg     <= 1'b0;
    end else begin
      if (force_p && lfa_reg) begin
        force_pend_reg <= 1'b1;
      end else if (t_lock || !lfa_reg) begin
        force_pend_reg <= 1'b0;
      end
      if (!lfa_reg || slip) begin
        tgood_reg <= '0;
      end else if (t_hunt) begin
        tgood_reg <= tgood_reg + 4'h1;
      end
      if (!lmfa_reg || jump || lfa_reg) begin
        mgood_reg <= '0;
      end else if (m_hunt) begin
        mgood_reg <= mgood_reg + 4'h1;
      end
      if (lfa_reg) begin
        mbad_reg   <= '0;
        mf_err_reg <= 1'b0;
      end else if (mf_end) begin
        mbad_reg   <= mf_bad ? mbad_reg + 3'h1 : 3'h0;
        mf_err_reg <= 1'b0;
      end else if (term_ev && !term_ok) begin
        mf_err_reg <= 1'b1;
      end
      if (is_f) begin
        ts_one_reg <= 1'b0;
      end else if (bit_stb && bit_idx[2:0] == 3'h2 && bit_val) begin
        ts_one_reg <= 1'b1;
      end
    end
  end

  // Position outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_num_reg <= '0;
      dl_bit_reg    <= 1'b0;
      dl_valid_reg  <= 1'b0;
      crc_bit_reg   <= 1'b0;
      crc_valid_reg <= 1'b0;
      sig_frame_reg <= 1'b0;
      sig_chan_reg  <= '0;
    end else begin
      dl_valid_reg  <= is_f & esf & !lmfa_reg & !frame_idx[0];
      crc_valid_reg <= is_f & esf & !lmfa_reg & (frame_idx[1:0] == 2'h1);
      if (is_f) begin
        frame_num_reg <= frame_idx;
        dl_bit_reg    <= bit_val;
        crc_bit_reg   <= bit_val;
        sig_frame_reg <= sig_dec & !lmfa_reg & !f4;
        sig_chan_reg  <= sig_chan_dec;
      end
    end
  end

  assign prdata                     = prdata_reg;
  assign pready                     = pready_reg;
  assign pslverr                    = pslverr_reg;
  assign frame_align_lost_flag      = lfa_reg;
  assign multiframe_align_lost_flag = lmfa_reg;
  assign remote_alarm               = ra_reg;
  assign frame_num                  = frame_num_reg;
  assign link_channel_bit           = dl_bit_reg;
  assign link_channel_valid         = dl_valid_reg;
  assign crc_bit                    = crc_bit_reg;
  assign crc_valid                  = crc_valid_reg;
  assign sig_frame                  = sig_frame_reg;
  assign sig_chan                   = sig_chan_reg;
  assign irq                        = irq_reg;

  property p_lfa_lmfa;
    @(posedge pclk) disable iff (!presetn) lfa_reg |-> lmfa_reg;
  endproperty
  a_lfa_lmfa: assert property (p_lfa_lmfa) else $error("Frame lost but multiframe kept");

  property p_sep_keep;
    @(posedge pclk) disable iff (!presetn)
      (mf_loss && !term_loss && !lfa_reg && !force_p) |=> !lfa_reg && lmfa_reg;
  endproperty
  a_sep_keep: assert property (p_sep_keep) else $error("Separated loss touched frame");

  property p_dl_pos;
    @(posedge pclk) disable iff (!presetn)
      link_channel_valid |-> $past(esf) && !frame_num_reg[0];
  endproperty
  a_dl_pos: assert property (p_dl_pos) else $error("Link bit at wrong frame");

  property p_crc_pos;
    @(posedge pclk) disable iff (!presetn)
      crc_valid |-> frame_num_reg[1:0] == 2'h1;
  endproperty
  a_crc_pos: assert property (p_crc_pos) else $error("CRC bit at wrong frame");

  property p_force_sync;
    @(posedge pclk) disable iff (!presetn)
      (force_p && !lfa_reg) |=> lfa_reg ##1 lfa_reg;
  endproperty
  a_force_sync: assert property (p_force_sync) else $error("Forced resync not honoured");

  sequence s_mf_hunting;
    !lfa_reg && lmfa_reg && !esf && !f4;
  endsequence
  property p_mf_regain;
    @(posedge pclk) disable iff (!presetn)
      s_mf_hunting ##1 !lmfa_reg |-> $past(mgood_reg) == tms_pkg::MF_GOOD - 4'h1;
  endproperty
  a_mf_regain: assert property (p_mf_regain) else $error("Multiframe regained too early");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      (lfa_next && !lfa_reg && imsk_reg[tms_pkg::IRQ_LFA]) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt missing");
endmodule
`default_nettype wire

// ### tms_line_src.sv
// Remote T1 terminal model sending a framed 12-frame line stream
`timescale 1ns/1ps
`default_nettype none
module tms_line_src (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Stimulus
  input  wire logic [31:0] rnd,
  input  wire logic        inv_ft,
  input  wire logic        inv_fs,
  input  wire logic        ra_on,
  // Line
  output logic             line_clk,
  output logic             line_data,
  output logic      [6:0]  frm,
  output logic             fpulse
);
  localparam logic [5:0] SF_SEQ = 6'h1C;
  logic [1:0] ph_reg;
  logic [7:0] bit_reg;
  logic [2:0] pat_idx;
  logic       fbit;
  logic       ra_bit;
  assign pat_idx = frm[3:1];
  // Remote alarm raises the frame 12 alignment bit
  assign ra_bit = ra_on & (frm == 7'h0B);
  // Odd frames terminal 1,0 alternating; even frames pattern 001110
  assign fbit = frm[0] ? ((SF_SEQ[pat_idx] | ra_bit) ^ inv_fs) : (~frm[1] ^ inv_ft);
  // Bit period of 4 pclk, high and low 2 pclk each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_reg    <= 2'h0;
      bit_reg   <= 8'h00;
      frm       <= 7'h00;
      line_clk  <= 1'b0;
      line_data <= 1'b0;
      fpulse    <= 1'b0;
    end else begin
      ph_reg <= ph_reg + 2'h1;
      fpulse <= 1'b0;
      if (ph_reg == 2'h0) begin
        line_data <= (bit_reg == 8'h00) ? fbit : rnd[0];
        fpulse    <= (bit_reg == 8'h00);
      end
      if (ph_reg == 2'h1) line_clk <= 1'b1;
      if (ph_reg == 2'h3) begin
        line_clk <= 1'b0;
        // 193 bits a frame, 12 frames a multiframe
        if (bit_reg == 8'hC0) begin
          bit_reg <= 8'h00;
          frm     <= (frm == 7'h0B) ? 7'h00 : frm + 7'h01;
        end else begin
          bit_reg <= bit_reg + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### tms_mf_sync_bench.sv
// Self-checking bench for the T1 multiframe synchronizer
`timescale 1ns/1ps
`default_nettype none
module tms_mf_sync_bench;
  logic        pclk = 1'b0;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        line_clk;
  logic        line_data;
  logic        lfa;
  logic        lmfa;
  logic        irq;
  logic        sig_frame;
  logic        sig_q = 1'b0;
  logic        ra;
  logic        ra_on;
  logic [1:0]  sig_chan;
  logic [6:0]  frame_num;
  logic [6:0]  frm;
  logic        fpulse;
  logic        inv_ft;
  logic        inv_fs;
  logic [31:0] rnd = 32'h8D5FF2E7;
  logic [32:0] expq[$];
  int          num_errors = 0;
  int          check_count = 0;

  always #20 pclk = ~pclk;

  tms_mf_sync dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_clk(line_clk), .line_data(line_data),
    .frame_align_lost_flag(lfa), .multiframe_align_lost_flag(lmfa),
    .remote_alarm(ra), .frame_num(frame_num), .link_channel_bit(),
    .link_channel_valid(), .crc_bit(), .crc_valid(), .sig_frame(sig_frame),
    .sig_chan(sig_chan), .irq(irq));

  tms_line_src far (.pclk(pclk), .presetn(presetn), .rnd(rnd), .inv_ft(inv_ft),
    .inv_fs(inv_fs), .line_clk(line_clk), .line_data(line_data), .frm(frm),
    .fpulse(fpulse), .ra_on(ra_on));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  always @(posedge pclk) rnd <= xs(rnd);

  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic tmo;
    num_errors++;
    conclude();
  endtask

  task automatic cmp_lv(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
    cmp_lv(got, exp);
  endtask

  // One APB transfer, idle cycle before its setup
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) tmo();
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_st(input logic [1:0] e, input int lim);
    int n;
    n = 0;
    while ({lmfa, lfa} !== e && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim) tmo();
  endtask

  task automatic wait_ra(input logic e, input int lim);
    int n;
    n = 0;
    while (ra !== e && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim) tmo();
  endtask

  task automatic frames(input int cnt);
    int k;
    repeat (cnt) begin
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (fpulse !== 1'b1 && k < 2000);
      if (k >= 2000) tmo();
    end
  endtask

  // Read results in issue order
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && expq.size() > 0)
      cmp_rd({pslverr, prdata}, expq.pop_front());
  end

  // Signaling frame position against the far end's frame
  always @(posedge pclk) begin
    sig_q <= sig_frame;
    if (sig_frame === 1'b1 && sig_q === 1'b0 && lmfa === 1'b0) begin
      cmp_lv(33'({sig_chan, frm}), (frm == 7'h0B) ? 33'h08B : 33'h005);
      cmp_lv(33'(frame_num), 33'(frm));
    end
  end

  initial begin
    ra_on   = 1'b0;
    presetn = 1'b0;
    paddr   = 8'h00;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h0;
    inv_ft  = 1'b0;
    inv_fs  = 1'b0;
    repeat (3) @(posedge pclk);
    cmp_lv({lmfa, lfa, pready}, 33'h6);
    presetn <= 1'b1;
    rd(tms_pkg::OFF_CTRL, 33'h0);
    rd(8'h10, {1'b1, 32'h0});
    // 12-frame format, separated resync, 2 of 4
    apb(1'b1, tms_pkg::OFF_CTRL, 32'h9);
    rd(tms_pkg::OFF_CTRL, 33'h9);
    apb(1'b1, tms_pkg::OFF_IMSK, 32'h3);
    wait_st(2'h0, 60000);
    cmp_lv({lmfa, lfa}, 33'h0);
    apb(1'b1, tms_pkg::OFF_ISTA, 32'h7);
    rd(tms_pkg::OFF_ISTA, 33'h0);
    frames(12);
    // Two bad multiframe bits
    inv_fs <= 1'b1;
    frames(4);
    inv_fs <= 1'b0;
    wait_st(2'h2, 8000);
    cmp_lv({lmfa, lfa}, 33'h2);
    cmp_lv(33'(irq), 33'h1);
    rd(tms_pkg::OFF_ISTA, 33'h2);
    apb(1'b1, tms_pkg::OFF_ISTA, 32'h2);
    repeat (2) @(posedge pclk);
    cmp_lv(33'(irq), 33'h0);
    wait_st(2'h0, 40000);
    cmp_lv({lmfa, lfa}, 33'h0);
    // Remote alarm carried by the frame 12 alignment bit
    apb(1'b1, tms_pkg::OFF_CTRL, 32'h5);
    ra_on <= 1'b1;
    wait_ra(1'b1, 10000);
    cmp_lv(33'(ra), 33'h1);
    rd(tms_pkg::OFF_ISTA, 33'h4);
    ra_on <= 1'b0;
    wait_ra(1'b0, 10000);
    cmp_lv(33'({ra, lmfa, lfa}), 33'h0);
    // Combined resync, 2 of 5, two bad terminal bits
    apb(1'b1, tms_pkg::OFF_CTRL, 32'h11);
    inv_ft <= 1'b1;
    frames(4);
    inv_ft <= 1'b0;
    wait_st(2'h3, 8000);
    cmp_lv({lmfa, lfa}, 33'h3);
    repeat (2) @(posedge pclk);
    cmp_lv(33'(irq), 33'h1);
    // Forced lock while hunting, then forced search while locked
    apb(1'b1, tms_pkg::OFF_CTRL, 32'h51);
    wait_st(2'h2, 1700);
    cmp_lv({lmfa, lfa}, 33'h2);
    apb(1'b1, tms_pkg::OFF_CTRL, 32'h51);
    wait_st(2'h3, 10);
    cmp_lv({lmfa, lfa}, 33'h3);
    conclude();
  end
endmodule
`default_nettype wire
